// ===== qae_pkg.sv
// constants, register map and types of the answer evaluator
// assumes an apb slave in a single pclk domain
//
// Notes on behaviour
// - full correct sequence: decrement, clear flags, new question
// - any other sequence: increment, keep question
// - fourth answer in window one: premature, wrong if any answer was wrong
// - three right then none: only timeout flag
// - one or two then none: order fault, timeout
// - four done in window two: wrong as answered, order fault if window one short
// - under four at window end: timeout, wrong if any answer was wrong
// - next cycle at fourth answer or window end
// - two-bit tally reads three after fourth answer
package qae_pkg;

	// ***************************************
	// register map
	// ***************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

	// ***************************************
	// fields
	// ***************************************
	localparam int CTRL_EN_BIT = 0;
	localparam int FLAG_WRONG_BIT = 0;
	localparam int FLAG_EARLY_BIT = 1;
	localparam int FLAG_ORDER_BIT = 2;
	localparam int FLAG_TIMEOUT_BIT = 3;
	localparam int STAT_TALLY_LSB = 4;
	localparam int STAT_LIVE_LSB = 8;
	localparam int IRQ_PASS_BIT = 0;
	localparam int IRQ_FAIL_BIT = 1;

	// ***************************************
	// reset values and counts
	// ***************************************
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [1:0] IRQ_RST = 2'h0;
	localparam logic [2:0] LAST_INDEX = 3'h3;
	localparam logic [2:0] WIN1_NEEDED = 3'h3;
	localparam logic [1:0] TALLY_FULL = 2'h3;

	typedef enum logic [1:0] {
		QAE_IDLE = 2'b01,
		QAE_RUN = 2'b10
	} qae_state_type;

endpackage : qae_pkg

// ===== qae_evaluator.sv
// answer evaluator of a question-and-answer watchdog with apb registers
// assumes answer strobes, window phase and window end come from pclk logic
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module qae_evaluator (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// answers and windows
	input wire logic reply_strobe,
	input wire logic reply_ok,
	input wire logic in_second_window,
	input wire logic second_window_end,
	// cycle control
	output logic cycle_start,
	output logic fail_count_up,
	output logic fail_count_down,
	output logic new_question,
	// status
	output logic wrong_reply_flag,
	output logic premature_reply_flag,
	output logic order_fault_flag,
	output logic timeout_flag,
	output logic [1:0] reply_tally,
	output logic irq
);

	// ***************************************
	// apb decode
	// ***************************************
	logic acc, wr;
	logic hit_ctrl, hit_stat, hit_irq, hit_mask, mapped;
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign hit_ctrl = paddr == qae_pkg::CTRL_OFS;
	assign hit_stat = paddr == qae_pkg::STATUS_OFS;
	assign hit_irq = paddr == qae_pkg::IRQ_STAT_OFS;
	assign hit_mask = paddr == qae_pkg::IRQ_MASK_OFS;
	assign mapped = hit_ctrl | hit_stat | hit_irq | hit_mask;
	// zero wait states keeps the answer path simple
	assign pready = 1'b1;
	// unmapped offsets answer with an error, never with a stall
	assign pslverr = acc & ~mapped;

	// ***************************************
	// state
	// ***************************************
	qae_pkg::qae_state_type state_q, state_d;
	logic en_q, en_d;
	logic [2:0] cnt_q, cnt_d;
	logic [2:0] w1_q, w1_d;
	logic bad_q, bad_d;
	logic [3:0] flags_q, flags_d;
	logic [1:0] tally_q, tally_d;
	logic [1:0] irq_stat_q, irq_stat_d;
	logic [1:0] irq_mask_q, irq_mask_d;
	logic start_q, start_d, up_q, up_d, down_q, down_d, newq_q, newq_d;
	logic [31:0] rdata_q, rdata_d;

	logic running, ans, fourth, evaluate, early, pass, bad_now;
	logic [2:0] w1_now;
	logic [1:0] live_tally;

	assign running = state_q == qae_pkg::QAE_RUN;
	assign ans = running & reply_strobe;
	assign fourth = ans & (cnt_q == qae_pkg::LAST_INDEX);
	// a fourth answer in the same cycle as window end takes precedence
	assign evaluate = fourth | (running & second_window_end);
	assign early = fourth & ~in_second_window;
	// an answer taken together with window end still counts toward the verdict
	assign bad_now = bad_q | (ans & ~reply_ok);
	assign w1_now = w1_q + {2'b00, ans & ~in_second_window};
	assign pass = fourth & ~early & ~bad_now & (w1_now == qae_pkg::WIN1_NEEDED);
	// tally lags the count by one, so three only ever means four answers
	assign live_tally = (cnt_q == 3'h0) ? 2'h0 : 2'(cnt_q - 3'h1);

	// ***************************************
	// next values
	// ***************************************
	always_comb begin
		state_d = state_q;
		en_d = en_q;
		cnt_d = cnt_q;
		w1_d = w1_q;
		bad_d = bad_q;
		flags_d = flags_q;
		tally_d = tally_q;
		irq_stat_d = irq_stat_q;
		irq_mask_d = irq_mask_q;
		start_d = 1'b0;
		up_d = 1'b0;
		down_d = 1'b0;
		newq_d = 1'b0;
		rdata_d = rdata_q;
		if (wr && hit_ctrl) begin
			en_d = pwdata[qae_pkg::CTRL_EN_BIT];
		end
		if (wr && hit_mask) begin
			irq_mask_d = pwdata[1:0];
		end
		if (wr && hit_irq) begin
			irq_stat_d = irq_stat_q & ~pwdata[1:0];
		end
		case (state_q)
			// strobes in the idle cycle after enable are not counted
			qae_pkg::QAE_IDLE: begin
				cnt_d = 3'h0;
				w1_d = 3'h0;
				bad_d = 1'b0;
				if (en_q) begin
					state_d = qae_pkg::QAE_RUN;
					start_d = 1'b1;
				end
			end
			qae_pkg::QAE_RUN: begin
				// disabling abandons the cycle but leaves the last verdict readable
				if (!en_q) begin
					state_d = qae_pkg::QAE_IDLE;
				end else if (evaluate) begin
					cnt_d = 3'h0;
					w1_d = 3'h0;
					bad_d = 1'b0;
					start_d = 1'b1;
					tally_d = fourth ? qae_pkg::TALLY_FULL : live_tally;
					flags_d[qae_pkg::FLAG_WRONG_BIT] = bad_now;
					flags_d[qae_pkg::FLAG_EARLY_BIT] = early;
					// order fault: window one short of three answers, window two reached
					flags_d[qae_pkg::FLAG_ORDER_BIT] = ~early
						& (w1_now < qae_pkg::WIN1_NEEDED);
					flags_d[qae_pkg::FLAG_TIMEOUT_BIT] = ~fourth;
					if (pass) begin
						flags_d = qae_pkg::FLAGS_RST;
						down_d = 1'b1;
						newq_d = 1'b1;
					end else begin
						up_d = 1'b1;
					end
					// hardware set wins over a same-cycle software clear
					irq_stat_d[qae_pkg::IRQ_PASS_BIT] = irq_stat_d[qae_pkg::IRQ_PASS_BIT] | pass;
					irq_stat_d[qae_pkg::IRQ_FAIL_BIT] = irq_stat_d[qae_pkg::IRQ_FAIL_BIT] | ~pass;
				end else if (ans) begin
					cnt_d = cnt_q + 3'h1;
					w1_d = w1_now;
					bad_d = bad_now;
				end
			end
			default: begin
				state_d = qae_pkg::QAE_IDLE;
			end
		endcase
		// captured in setup, so an evaluation in the access cycle cannot tear it
		if (psel && !penable && !pwrite) begin
			rdata_d = 32'h0000_0000;
			if (hit_ctrl) begin
				rdata_d[qae_pkg::CTRL_EN_BIT] = en_q;
			end
			if (hit_stat) begin
				rdata_d[3:0] = flags_q;
				rdata_d[qae_pkg::STAT_TALLY_LSB +: 2] = tally_q;
				rdata_d[qae_pkg::STAT_LIVE_LSB +: 2] = live_tally;
			end
			if (hit_irq) begin
				rdata_d[1:0] = irq_stat_q;
			end
			if (hit_mask) begin
				rdata_d[1:0] = irq_mask_q;
			end
		end
	end

	// ***************************************
	// registers
	// ***************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= qae_pkg::QAE_IDLE;
			en_q <= qae_pkg::CTRL_EN_RST;
			cnt_q <= 3'h0;
			w1_q <= 3'h0;
			bad_q <= 1'b0;
			flags_q <= qae_pkg::FLAGS_RST;
			tally_q <= 2'h0;
			irq_stat_q <= qae_pkg::IRQ_RST;
			irq_mask_q <= qae_pkg::IRQ_RST;
			start_q <= 1'b0;
			up_q <= 1'b0;
			down_q <= 1'b0;
			newq_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			en_q <= en_d;
			cnt_q <= cnt_d;
			w1_q <= w1_d;
			bad_q <= bad_d;
			flags_q <= flags_d;
			tally_q <= tally_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			start_q <= start_d;
			up_q <= up_d;
			down_q <= down_d;
			newq_q <= newq_d;
			rdata_q <= rdata_d;
		end
	end

	// ***************************************
	// outputs
	// ***************************************
	assign prdata = rdata_q;
	assign cycle_start = start_q;
	assign fail_count_up = up_q;
	assign fail_count_down = down_q;
	assign new_question = newq_q;
	assign wrong_reply_flag = flags_q[qae_pkg::FLAG_WRONG_BIT];
	assign premature_reply_flag = flags_q[qae_pkg::FLAG_EARLY_BIT];
	assign order_fault_flag = flags_q[qae_pkg::FLAG_ORDER_BIT];
	assign timeout_flag = flags_q[qae_pkg::FLAG_TIMEOUT_BIT];
	assign reply_tally = tally_q;
	assign irq = |(irq_stat_q & irq_mask_q);

	// ***************************************
	// assertions
	// ***************************************
	// all properties share pclk and drop out while reset is low
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pass_decrements: assert property ((en_q && pass) |=> fail_count_down && new_question
		&& !fail_count_up && flags_q == 4'h0)
		else $error("correct sequence not rewarded");
	a_fail_increments: assert property ((en_q && evaluate && !pass) |=> fail_count_up
		&& !new_question && !fail_count_down)
		else $error("bad sequence not penalised");
	a_early_wrong: assert property ((en_q && fourth && !in_second_window) |=>
		premature_reply_flag && (wrong_reply_flag == $past(bad_now)) && !timeout_flag)
		else $error("early answer flags wrong");
	a_timeout_only: assert property ((en_q && evaluate && !fourth && w1_now == 3'h3
		&& !bad_now) |=> flags_q == 4'h8)
		else $error("timeout after window one not alone");
	a_order_timeout: assert property ((en_q && evaluate && !fourth && w1_now != 3'h0
		&& w1_now < 3'h3 && cnt_d == 3'h0 && cnt_q == w1_q && !ans) |=>
		order_fault_flag && timeout_flag)
		else $error("short window one not flagged");
	a_window2_wrong: assert property ((en_q && fourth && in_second_window && bad_now)
		|=> wrong_reply_flag && !timeout_flag && !premature_reply_flag)
		else $error("wrong answer in window two not flagged");
	a_short_timeout: assert property ((en_q && evaluate && !fourth) |=> timeout_flag
		&& wrong_reply_flag == $past(bad_now))
		else $error("missing answers not flagged");
	a_next_cycle: assert property ((en_q && evaluate) |=> cycle_start ##1 !cycle_start)
		else $error("next cycle not started");
	a_tally_full: assert property ((en_q && fourth) |=> reply_tally == 2'h3)
		else $error("tally not full after fourth answer");
	a_tally_short: assert property ((en_q && evaluate && !fourth) |=> reply_tally < 2'h3)
		else $error("tally full without fourth answer");
	a_flags_held: assert property (!(running && en_q && evaluate) |=> $stable(flags_q))
		else $error("flags changed without evaluation");
	a_irq_level: assert property ((en_q && evaluate && !pass) |=> irq_stat_q[qae_pkg::IRQ_FAIL_BIT]
		&& (irq || !irq_mask_q[qae_pkg::IRQ_FAIL_BIT]))
		else $error("fail event not latched");
	a_pass_irq: assert property ((en_q && pass) |=> irq_stat_q[qae_pkg::IRQ_PASS_BIT]
		&& (irq || !irq_mask_q[qae_pkg::IRQ_PASS_BIT]))
		else $error("pass event not latched");
	a_set_wins: assert property ((en_q && evaluate && !pass && wr && hit_irq) |=>
		irq_stat_q[qae_pkg::IRQ_FAIL_BIT])
		else $error("clear beat a same-cycle fail event");
	a_clear_works: assert property ((wr && hit_irq && !evaluate && pwdata[qae_pkg::IRQ_FAIL_BIT])
		|=> !irq_stat_q[qae_pkg::IRQ_FAIL_BIT])
		else $error("fail event not cleared");
	a_idle_quiet: assert property (!running |=> !fail_count_up && !fail_count_down && !new_question)
		else $error("counter pulse while idle");
	a_idle_frozen: assert property (!running |=> $stable(flags_q) && $stable(tally_q))
		else $error("verdict changed while idle");
	a_read_held: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed outside setup");
	a_start_enable: assert property ((!running && en_q) |=> cycle_start && running)
		else $error("enable did not start a cycle");

	// ***************************************
	// cover points
	// ***************************************
	c_pass: cover property (en_q && pass ##1 fail_count_down);
	c_early: cover property (en_q && fourth && !in_second_window);
	c_timeout: cover property (en_q && second_window_end && !fourth && running);
	c_clear_race: cover property (wr && hit_irq && running && evaluate);
	c_order: cover property (en_q && evaluate && !fourth && w1_now < qae_pkg::WIN1_NEEDED);

endmodule : qae_evaluator

`default_nettype wire

// ===== qae_host_model.sv
// host side of the evaluator: answer strobes and the end of window two
// assumes its tasks are called from pclk-synchronous bench code
`timescale 1ns/1ps
`default_nettype none

module qae_host_model (
	// clock
	input wire logic pclk,
	// answers and windows
	output logic reply_strobe,
	output logic reply_ok,
	output logic in_second_window,
	output logic second_window_end
);
	initial begin
		reply_strobe = 1'b0;
		reply_ok = 1'b0;
		in_second_window = 1'b0;
		second_window_end = 1'b0;
	end

	// ok flips once released, so a stale answer is never trusted
	task automatic answer(input logic ok, input logic win2);
		@(posedge pclk);
		reply_strobe <= 1'b1;
		reply_ok <= ok;
		in_second_window <= win2;
		@(posedge pclk);
		reply_strobe <= 1'b0;
		reply_ok <= ~ok;
	endtask : answer

	task automatic window_end();
		@(posedge pclk);
		in_second_window <= 1'b1;
		second_window_end <= 1'b1;
		@(posedge pclk);
		second_window_end <= 1'b0;
	endtask : window_end
endmodule : qae_host_model
`default_nettype wire

// ===== qae_evaluator_tb.sv
// self-checking bench of the answer evaluator
// assumes zero-wait apb and one-cycle evaluation
`timescale 1ns/1ps
`default_nettype none

module qae_evaluator_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, cycle_start, fail_count_up, fail_count_down, new_question;
	logic reply_strobe, reply_ok, in_second_window, second_window_end;
	logic wrong_reply_flag, premature_reply_flag, order_fault_flag, timeout_flag;
	logic [1:0] reply_tally;
	int error_cnt = 0;
	int cmp_count = 0;

	always #2 pclk = ~pclk;

	qae_evaluator i_qae_evaluator (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .reply_strobe, .reply_ok, .in_second_window,
		.second_window_end, .cycle_start, .fail_count_up, .fail_count_down, .new_question,
		.wrong_reply_flag, .premature_reply_flag, .order_fault_flag, .timeout_flag,
		.reply_tally, .irq);
	qae_host_model i_qae_host_model (.pclk, .reply_strobe, .reply_ok, .in_second_window,
		.second_window_end);

	// ***************************************
	// shared tasks
	// ***************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		input logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		chk(32'(pslverr), 32'(err));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// flags given as {timeout, order, premature, wrong}; all clear only on a pass
	task automatic run(input int n1, input int n2, input logic [3:0] okm, input logic wend,
		input logic [3:0] fl);
		int n;
		n = n1 + n2;
		for (int i = 0; i < n; i++) i_qae_host_model.answer(okm[i], i >= n1);
		if (wend) i_qae_host_model.window_end();
		#1;
		chk(32'(cycle_start), 32'h1);
		chk(32'({fail_count_up, fail_count_down, new_question}), (fl == 4'h0) ? 32'h3 : 32'h4);
		chk(32'({timeout_flag, order_fault_flag, premature_reply_flag, wrong_reply_flag}), 32'(fl));
		chk(32'(reply_tally), (n == 4) ? 32'h3 : (n == 0) ? 32'h0 : 32'(n - 1));
	endtask : run

	task automatic end_of_test();
		$display("errors %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	// ***************************************
	// scenarios
	// ***************************************
	task automatic t_pass();
		run(3, 1, 4'hF, 1'b0, 4'h0);
	endtask : t_pass

	task automatic t_late();
		run(3, 1, 4'h7, 1'b0, 4'h1);
		run(1, 3, 4'hF, 1'b0, 4'h4);
		run(0, 4, 4'h0, 1'b0, 4'h5);
	endtask : t_late

	task automatic t_early();
		run(4, 0, 4'hF, 1'b0, 4'h2);
		run(4, 0, 4'hA, 1'b0, 4'h3);
	endtask : t_early

	task automatic t_timeout();
		run(3, 0, 4'h7, 1'b1, 4'h8);
		run(2, 0, 4'h3, 1'b1, 4'hC);
		run(1, 0, 4'h1, 1'b1, 4'hC);
		run(3, 0, 4'h0, 1'b1, 4'h9);
		run(2, 1, 4'h0, 1'b1, 4'hD);
		run(0, 0, 4'h0, 1'b1, 4'hC);
	endtask : t_timeout

	// flags must stay readable while the next cycle runs
	task automatic t_regs();
		run(3, 0, 4'h7, 1'b1, 4'h8);
		apb(1'b0, qae_pkg::STATUS_OFS, 32'h0, 1'b0);
		chk(rd & 32'h3F, 32'h28);
		chk(32'(irq), 32'h0);
		apb(1'b1, qae_pkg::IRQ_MASK_OFS, 32'h2, 1'b0);
		#1;
		chk(32'(irq), 32'h1);
		apb(1'b1, qae_pkg::IRQ_STAT_OFS, 32'h3, 1'b0);
		#1;
		chk(32'(irq), 32'h0);
		apb(1'b0, 8'h10, 32'h0, 1'b1);
		chk(rd, 32'h0);
	endtask : t_regs

	// a clear that meets a failing evaluation loses to the set
	task automatic t_race();
		i_qae_host_model.answer(1'b1, 1'b0);
		i_qae_host_model.answer(1'b1, 1'b0);
		apb(1'b0, qae_pkg::STATUS_OFS, 32'h0, 1'b0);
		chk(rd & 32'h300, 32'h100);
		fork
			apb(1'b1, qae_pkg::IRQ_STAT_OFS, 32'h3, 1'b0);
			begin
				@(posedge pclk);
				i_qae_host_model.window_end();
			end
		join
		#1;
		chk(32'({timeout_flag, order_fault_flag, premature_reply_flag, wrong_reply_flag}), 32'hC);
		apb(1'b0, qae_pkg::IRQ_STAT_OFS, 32'h0, 1'b0);
		chk(rd, 32'h2);
		chk(32'(irq), 32'h1);
	endtask : t_race

	// disabling abandons the cycle and leaves the verdict readable
	task automatic t_ctrl();
		apb(1'b1, qae_pkg::CTRL_OFS, 32'h0, 1'b0);
		i_qae_host_model.answer(1'b0, 1'b0);
		i_qae_host_model.window_end();
		#1;
		chk(32'({timeout_flag, order_fault_flag, premature_reply_flag, wrong_reply_flag}), 32'hC);
		chk(32'({cycle_start, fail_count_up, fail_count_down, new_question}), 32'h0);
		apb(1'b1, qae_pkg::CTRL_OFS, 32'h1, 1'b0);
		@(posedge pclk);
		#1;
		chk(32'(cycle_start), 32'h1);
	endtask : t_ctrl

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk(32'({cycle_start, fail_count_up, fail_count_down, new_question, reply_tally, irq}), 32'h0);
		chk(32'({timeout_flag, order_fault_flag, premature_reply_flag, wrong_reply_flag, pready}), 32'h1);
		apb(1'b0, qae_pkg::CTRL_OFS, 32'h0, 1'b0);
		chk(rd, 32'h0);
		apb(1'b1, qae_pkg::CTRL_OFS, 32'h1, 1'b0);
		for (int n = 0; n < 20 && cycle_start !== 1'b1; n++) begin
			@(posedge pclk);
			#1;
		end
		chk(32'(cycle_start), 32'h1);
		t_pass();
		t_late();
		t_early();
		t_timeout();
		t_regs();
		t_race();
		t_ctrl();
		end_of_test();
	end

	// whole run needs about 150 cycles
	initial begin
		repeat (5000) @(posedge pclk);
		error_cnt++;
		end_of_test();
	end
endmodule : qae_evaluator_tb
`default_nettype wire
